/* File: cca_core.v */
// correlator core accumulate, blanking timing and host word path
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "cca_defs.vh"
module cca_core #(
	parameter CARDS = 26,
	parameter WORD_W = 20
) (
	input  wire                i_core_clk,
	input  wire                i_nrst,
	input  wire                i_ref_10k,
	input  wire                i_ref_0p1,
	input  wire [CARDS-1:0]    i_card_top_bit,
	input  wire [7:0]          i_card_value,
	input  wire [WORD_W-1:0]   i_knob_value,
	input  wire [WORD_W-1:0]   i_core_rdata,
	input  wire [WORD_W-1:0]   i_host_core_rdata,
	input  wire                i_host_ack,
	output reg  [4:0]          o_card_sel,
	output reg  [3:0]          o_card_chan,
	output reg  [8:0]          o_core_addr,
	output reg  [WORD_W-1:0]   o_core_wdata,
	output reg                 o_core_we,
	output reg  [8:0]          o_host_core_addr,
	output reg  [15:0]         o_host_word,
	output reg                 o_host_valid,
	output reg                 o_word_load_strobe,
	output reg                 o_integrate_flag,
	output reg                 o_mult_clk_en,
	output wire                o_shift_clk_en,
	output reg                 o_clear_counters,
	output reg                 o_shift_pulse_drive,
	output reg                 o_strobe_pulse_drive,
	output reg  [7:0]          o_sequence_state,
	output reg  [3:0]          o_seq_index,
	input  wire [31:0]         s_axi_awaddr,
	input  wire                s_axi_awvalid,
	output wire                s_axi_awready,
	input  wire [31:0]         s_axi_wdata,
	input  wire [3:0]          s_axi_wstrb,
	input  wire                s_axi_wvalid,
	output wire                s_axi_wready,
	output reg  [1:0]          s_axi_bresp,
	output reg                 s_axi_bvalid,
	input  wire                s_axi_bready,
	input  wire [31:0]         s_axi_araddr,
	input  wire                s_axi_arvalid,
	output wire                s_axi_arready,
	output reg  [31:0]         s_axi_rdata,
	output reg  [1:0]          s_axi_rresp,
	output reg                 s_axi_rvalid,
	input  wire                s_axi_rready
);
	reg  [4:0]        ctrl;
	reg  [16:0]       half_ticks;
	reg  [2:0]        s10k;
	reg  [2:0]        s0p1;
	reg               lvl_10k;
	reg               lvl_0p1;
	reg  [6:0]        step_cnt;
	reg  [4:0]        ph_cnt;
	reg  [1:0]        phase_counter;
	reg  [7:0]        sequence_counter;
	reg  [7:0]        next_seq;
	reg  [3:0]        next_idx;
	reg  [5:0]        align_cnt;
	reg  [16:0]       rate_divider;
	reg               switching_synchronizer;
	reg  [4:0]        ms_tick;
	reg  [3:0]        blanking_ms_counter;
	reg               blanking_flop;
	reg               flag_driver_stage;
	reg               blanking_end;
	reg  [1:0]        st;
	reg  [8:0]        integration_address_counter;
	reg  [2:0]        grp;
	reg  [7:0]        top_bit_capture_shift;
	reg  [7:0]        blanking_temp_shift [0:7];
	reg  [WORD_W-1:0] core_write_holding_register;
	reg               xfer_done;
	reg  [9:0]        host_cnt;
	reg               host_active;
	reg               host_pend;
	reg               computer_address_lsb;
	reg               host_sign;
	reg               aw_got;
	reg               w_got;
	reg  [3:0]        aw_off;
	reg  [31:0]       w_data;
	reg  [3:0]        w_strb;
	reg  [WORD_W-1:0] sum;
	wire              tick_10k;
	wire              mark_0p1;
	wire              step_en;
	wire              ph_en;
	wire [3:0]        blank_code;
	integer           k;

	// three-stage pin synchronisers, level moves once stages two and three agree
	always @(posedge i_core_clk)
	begin
		if (!i_nrst)
		begin
			s10k <= 3'b000;
			s0p1 <= 3'b000;
			lvl_10k <= 1'b0;
			lvl_0p1 <= 1'b0;
		end
		else
		begin
			s10k <= {s10k[1:0], i_ref_10k};
			s0p1 <= {s0p1[1:0], i_ref_0p1};
			if (s10k[1] == s10k[2])
				lvl_10k <= s10k[2];
			if (s0p1[1] == s0p1[2])
				lvl_0p1 <= s0p1[2];
		end
	end
	assign tick_10k = s10k[1] & s10k[2] & ~lvl_10k;
	assign mark_0p1 = s0p1[1] & s0p1[2] & ~lvl_0p1;

	// 750ns channel step and 250ns phase enables
	assign step_en = (step_cnt == `CCA_STEP_CYC - 7'd1);
	assign ph_en = (ph_cnt == `CCA_PHASE_CYC - 5'd1);
	always @(posedge i_core_clk)
	begin
		if (!i_nrst)
		begin
			step_cnt <= 7'd0;
			ph_cnt <= 5'd0;
			phase_counter <= 2'b00;
			o_shift_pulse_drive <= 1'b0;
			o_strobe_pulse_drive <= 1'b0;
			sequence_counter <= 8'h00;
			o_sequence_state <= 8'h00;
			o_seq_index <= 4'h0;
			o_card_chan <= 4'h0;
		end
		else
		begin
			step_cnt <= step_en ? 7'd0 : step_cnt + 7'd1;
			ph_cnt <= (ph_en | step_en) ? 5'd0 : ph_cnt + 5'd1;
			if (step_en)
				o_card_chan <= o_card_chan + 4'h1;
			if (step_en)
				phase_counter <= 2'b00;
			else if (ph_en)
			begin
				case (phase_counter)
				2'b00: phase_counter <= 2'b01;
				2'b01: phase_counter <= 2'b11;
				default: phase_counter <= 2'b00;
				endcase
			end
			o_shift_pulse_drive <= phase_counter[1];
			o_strobe_pulse_drive <= phase_counter[0];
			if (ph_en)
			begin
				sequence_counter <= next_seq;
				o_sequence_state <= next_seq;
				o_seq_index <= next_idx;
			end
		end
	end

	// shift code walk; unlisted states fall back to zero
	always @*
	begin
		next_seq = 8'h00;
		case (sequence_counter)
		8'h00: next_seq = 8'h01;
		8'h01: next_seq = 8'h07;
		8'h07: next_seq = 8'h0F;
		8'h0F: next_seq = 8'h1F;
		8'h1F: next_seq = 8'h3F;
		8'h3F: next_seq = 8'h7F;
		8'h7F: next_seq = 8'hFF;
		8'hFF: next_seq = 8'hFE;
		8'hFE: next_seq = 8'hF8;
		8'hF8: next_seq = 8'hE0;
		8'hE0: next_seq = 8'hC0;
		8'hC0: next_seq = 8'h80;
		default: next_seq = 8'h00;
		endcase
		// two-bit decodes of the state being entered
		next_idx = 4'h0;
		if (next_seq[7] & ~next_seq[6])
			next_idx = 4'hC;
		else if (next_seq[6] & ~next_seq[5])
			next_idx = 4'hB;
		else if (next_seq[5] & ~next_seq[3])
			next_idx = 4'hA;
		else if (next_seq[3] & ~next_seq[2])
			next_idx = 4'h9;
		else if (next_seq[0] & ~next_seq[1])
			next_idx = 4'h1;
		else if (next_seq[2] & ~next_seq[3])
			next_idx = 4'h2;
		else if (next_seq[3] & ~next_seq[4])
			next_idx = 4'h3;
		else if (next_seq[4] & ~next_seq[5])
			next_idx = 4'h4;
		else if (next_seq[5] & ~next_seq[6])
			next_idx = 4'h5;
		else if (next_seq[6] & ~next_seq[7])
			next_idx = 4'h6;
		else if (next_seq[7] & next_seq[0])
			next_idx = 4'h7;
		else if (next_seq[7] & next_seq[1])
			next_idx = 4'h8;
	end

	// rate divider, alignment pulse and blanking timer
	assign blank_code = (ctrl[3:0] > `CCA_BLANK_MAX) ? `CCA_BLANK_MAX
		: ctrl[3:0];
	assign o_shift_clk_en = 1'b1;
	always @(posedge i_core_clk)
	begin
		if (!i_nrst)
		begin
			align_cnt <= 6'd0;
			rate_divider <= 17'd0;
			switching_synchronizer <= 1'b0;
			ms_tick <= 5'd0;
			blanking_ms_counter <= 4'd0;
			blanking_end <= 1'b0;
			blanking_flop <= 1'b0;
			flag_driver_stage <= 1'b1;
			o_integrate_flag <= 1'b1;
			o_mult_clk_en <= 1'b1;
		end
		else
		begin
			if (mark_0p1)
				align_cnt <= `CCA_ALIGN_CYC;
			else if (align_cnt != 6'd0)
				align_cnt <= align_cnt - 6'd1;
			switching_synchronizer <= 1'b0;
			if (align_cnt != 6'd0)
				rate_divider <= 17'd0;
			else if (tick_10k)
			begin
				if (rate_divider >= half_ticks - 17'd1)
				begin
					rate_divider <= 17'd0;
					switching_synchronizer <= ctrl[4];
				end
				else
					rate_divider <= rate_divider + 17'd1;
			end
			if (!blanking_flop)
			begin
				ms_tick <= 5'd0;
				blanking_ms_counter <= 4'd0;
			end
			else if (tick_10k)
			begin
				if (ms_tick == `CCA_MS_TICKS - 5'd1)
				begin
					ms_tick <= 5'd0;
					blanking_ms_counter <= blanking_ms_counter + 4'd1;
				end
				else
					ms_tick <= ms_tick + 5'd1;
			end
			// length is (code+2) steps of 2ms
			blanking_end <= blanking_flop
				& (blanking_ms_counter == blank_code + 4'd2);
			if (switching_synchronizer)
				blanking_flop <= 1'b1;
			else if (blanking_end)
				blanking_flop <= 1'b0;
			flag_driver_stage <= ~blanking_flop;
			o_integrate_flag <= flag_driver_stage;
			o_mult_clk_en <= flag_driver_stage;
		end
	end

	// accumulate adder: top bit at the eighth weight, or whole byte
	always @*
	begin
		if (o_integrate_flag)
			sum = i_core_rdata
				+ ({{(WORD_W-1){1'b0}}, top_bit_capture_shift[0]}
				<< `CCA_BIT_WEIGHT);
		else
			sum = i_core_rdata
				+ {{(WORD_W-8){1'b0}}, blanking_temp_shift[grp]};
	end

	// core read-modify-write sequencer
	always @(posedge i_core_clk)
	begin
		if (!i_nrst)
		begin
			st <= `CCA_ST_CAPT;
			integration_address_counter <= 9'd0;
			grp <= 3'd0;
			top_bit_capture_shift <= 8'h00;
			for (k = 0; k < 8; k = k + 1)
				blanking_temp_shift[k] <= 8'h00;
			core_write_holding_register <= {WORD_W{1'b0}};
			o_core_wdata <= {WORD_W{1'b0}};
			o_core_we <= 1'b0;
			o_core_addr <= 9'd0;
			o_card_sel <= 5'd0;
			o_clear_counters <= 1'b0;
			xfer_done <= 1'b0;
		end
		else
		begin
			o_core_we <= 1'b0;
			o_clear_counters <= 1'b0;
			o_core_addr <= integration_address_counter;
			o_card_sel <= integration_address_counter[8:4];
			if (o_integrate_flag)
				xfer_done <= 1'b0;
			// a mode change restarts the address walk at word zero
			if (flag_driver_stage != o_integrate_flag)
			begin
				st <= `CCA_ST_CAPT;
				grp <= 3'd0;
				integration_address_counter <= 9'd0;
			end
			else
			case (st)
			`CCA_ST_CAPT:
			begin
				if (!o_integrate_flag & xfer_done)
					grp <= 3'd0;
				else if (step_en
					& (o_card_chan[2:0] == grp))
				begin
					// take this channel while it is on the card bus
					top_bit_capture_shift <= {
						i_card_top_bit[integration_address_counter[8:4]],
						top_bit_capture_shift[7:1]};
					blanking_temp_shift[grp] <= i_card_value;
					grp <= grp + 3'd1;
					if (grp == `CCA_GROUP_LAST)
						st <= `CCA_ST_RD;
				end
			end
			`CCA_ST_RD:
			begin
				st <= `CCA_ST_WR;
			end
			`CCA_ST_WR:
			begin
				if (!o_integrate_flag
					& (integration_address_counter >= `CCA_CHANNELS))
					core_write_holding_register <= i_knob_value;
				else
					core_write_holding_register <= sum;
				if (o_integrate_flag)
					top_bit_capture_shift <= {1'b0,
						top_bit_capture_shift[7:1]};
				st <= `CCA_ST_HOLD;
			end
			default:
			begin
				o_core_wdata <= core_write_holding_register;
				o_core_we <= 1'b1;
				grp <= grp + 3'd1;
				st <= (grp == `CCA_GROUP_LAST) ? `CCA_ST_CAPT : `CCA_ST_RD;
				if (o_integrate_flag
					& (integration_address_counter >= `CCA_CHANNELS - 9'd1))
					integration_address_counter <= 9'd0;
				else if (integration_address_counter == `CCA_LAST_WORD)
				begin
					integration_address_counter <= 9'd0;
					xfer_done <= 1'b1;
					o_clear_counters <= 1'b1;
				end
				else
					integration_address_counter <=
						integration_address_counter + 9'd1;
			end
			endcase
		end
	end

	// host word path: each word read twice, low 15 then high 5 bits
	always @(posedge i_core_clk)
	begin
		if (!i_nrst)
		begin
			host_cnt <= 10'd0;
			host_active <= 1'b0;
			host_pend <= 1'b0;
			computer_address_lsb <= 1'b0;
			host_sign <= 1'b1;
			o_host_core_addr <= 9'd0;
			o_host_word <= 16'h0000;
			o_host_valid <= 1'b0;
			o_word_load_strobe <= 1'b0;
		end
		else
		begin
			o_word_load_strobe <= 1'b0;
			host_pend <= 1'b0;
			if (o_clear_counters)
			begin
				host_cnt <= 10'd0;
				host_active <= 1'b1;
				host_pend <= 1'b1;
				host_sign <= 1'b1;
				o_host_valid <= 1'b0;
				o_host_core_addr <= 9'd0;
				computer_address_lsb <= 1'b0;
			end
			else if (host_pend)
			begin
				o_word_load_strobe <= 1'b1;
				o_host_valid <= 1'b1;
				if (computer_address_lsb)
					o_host_word <= {host_sign, 10'd0,
						i_host_core_rdata[WORD_W-1:`CCA_LO_BITS]};
				else
					o_host_word <= {host_sign,
						i_host_core_rdata[`CCA_LO_BITS-1:0]};
			end
			else if (i_host_ack & o_host_valid)
			begin
				o_host_valid <= 1'b0;
				host_sign <= ~host_sign;
				if (host_cnt == {`CCA_LAST_WORD, 1'b1})
					host_active <= 1'b0;
				else
				begin
					host_cnt <= host_cnt + 10'd1;
					computer_address_lsb <= ~host_cnt[0];
					o_host_core_addr <= host_cnt[9:1] + {8'd0, host_cnt[0]};
					host_pend <= 1'b1;
				end
			end
		end
	end

	// register bus slave
	assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
	assign s_axi_wready = ~w_got & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	always @(posedge i_core_clk)
	begin
		if (!i_nrst)
		begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_off <= 4'h0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CCA_RESP_OK;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `CCA_RESP_OK;
			s_axi_rdata <= 32'h0000_0000;
			ctrl <= `CCA_CTRL_RST;
			half_ticks <= `CCA_HALF_RST;
		end
		else
		begin
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_got <= 1'b1;
				aw_off <= (s_axi_awaddr[31:4] == 28'd0) ? s_axi_awaddr[3:0]
					: 4'hF;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_got & w_got)
			begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `CCA_RESP_OK;
				if (aw_off == `CCA_OFF_CTRL)
				begin
					if (w_strb[0])
						ctrl <= w_data[4:0];
				end
				else if (aw_off == `CCA_OFF_HALF)
				begin
					if (w_strb[0])
						half_ticks[7:0] <= w_data[7:0];
					if (w_strb[1])
						half_ticks[15:8] <= w_data[15:8];
					if (w_strb[2])
						half_ticks[16] <= w_data[16];
				end
				else
					s_axi_bresp <= `CCA_RESP_ERR;
			end
			else if (s_axi_bvalid & s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_arvalid & s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `CCA_RESP_OK;
				s_axi_rdata <= 32'h0000_0000;
				if (s_axi_araddr == {28'd0, `CCA_OFF_CTRL})
					s_axi_rdata <= {27'd0, ctrl};
				else if (s_axi_araddr == {28'd0, `CCA_OFF_HALF})
					s_axi_rdata <= {15'd0, half_ticks};
				else if (s_axi_araddr == {28'd0, `CCA_OFF_STAT})
					s_axi_rdata <= {host_cnt, 5'd0,
						integration_address_counter, 4'd0, xfer_done,
						host_active, blanking_flop, o_integrate_flag};
				else
					s_axi_rresp <= `CCA_RESP_ERR;
			end
			else if (s_axi_rvalid & s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // cca_core

/* File: cca_core_bench.sv */
// self-checking bench for the correlator core accumulate block
`timescale 1ns/1ps
`include "cca_defs.vh"
module cca_core_bench;
logic        i_core_clk = 0, i_nrst = 0, i_ref_10k = 0, i_ref_0p1 = 0;
logic [25:0] i_card_top_bit = 26'h2AA_AAAA;
logic [7:0]  i_card_value = 8'h5A;
logic [19:0] i_knob_value = 20'hA_5C3E, i_core_rdata = 20'h0_1000;
logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
logic [3:0]  s_axi_wstrb = 4'hF;
logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
logic        s_axi_arvalid = 0, s_axi_rready = 0;
wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
wire         s_axi_arready, s_axi_rvalid, i_host_ack;
wire [1:0]   s_axi_bresp, s_axi_rresp;
wire [31:0]  s_axi_rdata;
wire [8:0]   o_core_addr, o_host_core_addr;
// host side core port: word ready in the same cycle as its address
wire [19:0]  i_host_core_rdata = {o_host_core_addr, 2'b01, o_host_core_addr};
wire [19:0]  o_core_wdata;
wire [15:0]  o_host_word;
wire         o_core_we, o_host_valid, o_word_load_strobe, o_integrate_flag;
wire [9:0]   h_bad;
wire [3:0]   h_xfers;
int          n_errors = 0, checks_done = 0, n_wr = 0, ref_half = 450;
logic [31:0] rd;
logic [1:0]  rsp;
logic [7:0]  fh = 8'hFF;
logic [19:0] wexp;
cca_core cca_core_i (.i_core_clk, .i_nrst, .i_ref_10k, .i_ref_0p1,
	.i_card_top_bit, .i_card_value, .i_knob_value, .i_core_rdata,
	.i_host_core_rdata, .i_host_ack, .o_card_sel(), .o_card_chan(),
	.o_core_addr, .o_core_wdata, .o_core_we, .o_host_core_addr, .o_host_word,
	.o_host_valid, .o_word_load_strobe, .o_integrate_flag, .o_mult_clk_en(),
	.o_shift_clk_en(), .o_clear_counters(), .o_shift_pulse_drive(),
	.o_strobe_pulse_drive(), .o_sequence_state(), .o_seq_index(),
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready);
cca_host_model cca_host_model_i (.i_clk(i_core_clk), .i_nrst,
	.i_word(o_host_word), .i_valid(o_host_valid),
	.i_strobe(o_word_load_strobe), .o_ack(i_host_ack), .o_bad(h_bad),
	.o_xfers(h_xfers));
always #5 i_core_clk = ~i_core_clk;
// reference sped up; slow enough that blanking holds a whole address walk
always
begin
	repeat (ref_half) @(posedge i_core_clk);
	i_ref_10k <= ~i_ref_10k;
end
task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
begin
	checks_done++;
	if (got !== exp)
	begin
		n_errors++;
		$display("BAD %0t got %h want %h", $time, got, exp);
	end
end
endtask
task automatic check_num(input int got, input int lo, input int hi);
begin
	checks_done++;
	if (got < lo || got > hi)
	begin
		n_errors++;
		$display("BAD %0t count %0d", $time, got);
	end
end
endtask
// core writes judged only while the flag has been steady
always @(posedge i_core_clk)
begin
	fh <= {fh[6:0], o_integrate_flag};
	if (o_core_we && (&fh || ~|fh))
	begin
		n_wr++;
		wexp = o_core_addr > 9'h19F ? i_knob_value : i_core_rdata
			+ (fh[0] ? {o_core_addr[4], 7'h00} : i_card_value);
		check_word(o_core_wdata, wexp);
	end
end
task automatic axi_wr(input logic [31:0] a, d, output logic [1:0] r);
	logic ta, tw, tb;
begin
	@(posedge i_core_clk);
	s_axi_awaddr <= a;
	s_axi_wdata <= d;
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	s_axi_bready <= 1'b1;
	do
	begin
		@(posedge i_core_clk);
		ta = s_axi_awvalid && s_axi_awready;
		tw = s_axi_wvalid && s_axi_wready;
		tb = s_axi_bvalid && s_axi_bready;
		r = s_axi_bresp;
		if (ta) s_axi_awvalid <= 1'b0;
		if (tw) s_axi_wvalid <= 1'b0;
		if (tb) s_axi_bready <= 1'b0;
	end while (!tb);
end
endtask
task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
	output logic [1:0] r);
	logic ta, tb;
begin
	@(posedge i_core_clk);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'b1;
	s_axi_rready <= 1'b1;
	do
	begin
		@(posedge i_core_clk);
		ta = s_axi_arvalid && s_axi_arready;
		tb = s_axi_rvalid && s_axi_rready;
		d = s_axi_rdata;
		r = s_axi_rresp;
		if (ta) s_axi_arvalid <= 1'b0;
		if (tb) s_axi_rready <= 1'b0;
	end while (!tb);
end
endtask
task t_regs;
begin
	axi_rd(`CCA_OFF_CTRL, rd, rsp);
	check_word(rd, 32'h0000_0010);
	axi_rd(`CCA_OFF_HALF, rd, rsp);
	check_word(rd, 32'h0000_1388);
	axi_rd(32'h0000_000C, rd, rsp);
	check_word(rd, 32'h0000_0000);
	check_word(rsp, `CCA_RESP_ERR);
	axi_wr(32'h0000_000C, 32'h0000_0001, rsp);
	check_word(rsp, `CCA_RESP_ERR);
	axi_wr(`CCA_OFF_HALF, 32'h0000_0258, rsp);
	axi_rd(`CCA_OFF_HALF, rd, rsp);
	check_word(rd, 32'h0000_0258);
	axi_rd(`CCA_OFF_STAT, rd, rsp);
	check_word(rd[0], 1'b1);
end
endtask
task automatic t_blank(input logic [3:0] code, input int ticks);
	int n;
	logic prev;
begin
	axi_wr(`CCA_OFF_CTRL, {27'h000_0000, 1'b1, code}, rsp);
	n = 0;
	while (o_integrate_flag !== 1'b1) @(negedge i_core_clk);
	while (o_integrate_flag !== 1'b0) @(negedge i_core_clk);
	prev = i_ref_10k;
	while (o_integrate_flag === 1'b0)
	begin
		@(negedge i_core_clk);
		n += i_ref_10k && !prev;
		prev = i_ref_10k;
	end
	check_num(n, ticks - 2, ticks + 2);
end
endtask
task t_host;
begin
	while (h_xfers === 4'h0) @(negedge i_core_clk);
	check_word(h_bad, 10'h000);
end
endtask
task test_done;
begin
	$display("errors %0d checks %0d", n_errors, checks_done);
	if (n_errors == 0 && checks_done > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
end
endtask
initial
begin
	repeat (90000) @(posedge i_core_clk);
	n_errors++;
	$display("BAD %0t timeout", $time);
	test_done;
end
initial
begin
	repeat (16) @(posedge i_core_clk);
	i_nrst <= 1'b1;
	t_regs;
	i_ref_0p1 <= 1'b1;
	repeat (100) @(posedge i_core_clk);
	i_ref_0p1 <= 1'b0;
	// short switching half period so blanking starts soon
	axi_wr(`CCA_OFF_HALF, 32'h0000_0002, rsp);
	check_word(rsp, `CCA_RESP_OK);
	t_blank(4'h0, 40);
	t_host;
	ref_half = 10;
	t_blank(4'hF, 240);
	check_num(n_wr, 1, 1000000);
	test_done;
end
endmodule // cca_core_bench

/* File: cca_core_chk.sv */
// port checker for the correlator core accumulate block
`timescale 1ns/1ps
module cca_core_chk (
	input wire        i_core_clk,
	input wire        i_nrst,
	input wire [3:0]  o_card_chan,
	input wire        o_core_we,
	input wire [15:0] o_host_word,
	input wire        o_host_valid,
	input wire        o_word_load_strobe,
	input wire        o_integrate_flag,
	input wire        o_mult_clk_en,
	input wire        o_clear_counters,
	input wire [7:0]  o_sequence_state,
	input wire [3:0]  o_seq_index
);
default clocking cb @(posedge i_core_clk);
endclocking
default disable iff (!i_nrst);
reg [6:0] gap;
reg [3:0] chan_q;
reg       seen;
reg       have;
reg       last;
reg [3:0] idx_exp;
// place of the shift code in its listed walk
always @*
begin
	case (o_sequence_state)
	8'h01: idx_exp = 4'h1;
	8'h07: idx_exp = 4'h2;
	8'h0F: idx_exp = 4'h3;
	8'h1F: idx_exp = 4'h4;
	8'h3F: idx_exp = 4'h5;
	8'h7F: idx_exp = 4'h6;
	8'hFF: idx_exp = 4'h7;
	8'hFE: idx_exp = 4'h8;
	8'hF8: idx_exp = 4'h9;
	8'hE0: idx_exp = 4'hA;
	8'hC0: idx_exp = 4'hB;
	8'h80: idx_exp = 4'hC;
	default: idx_exp = 4'h0;
	endcase
end
// spacing of channel steps and sign of the previous host word
always @(posedge i_core_clk)
begin
	if (!i_nrst)
	begin
		gap <= 7'h00;
		chan_q <= 4'h0;
		seen <= 1'b0;
		have <= 1'b0;
		last <= 1'b0;
	end
	else
	begin
		gap <= (o_card_chan != chan_q) ? 7'h00 : gap + 7'h01;
		chan_q <= o_card_chan;
		seen <= seen | (o_card_chan != chan_q);
		have <= o_clear_counters ? 1'b0 : (have | o_word_load_strobe);
		last <= o_word_load_strobe ? o_host_word[15] : last;
	end
end
property p_chan_step; (o_card_chan != chan_q) && seen |-> gap == 7'h4A; endproperty
a_chan_step: assert property (p_chan_step) else $error("channel step spacing");
property p_mult_gate; o_mult_clk_en == o_integrate_flag; endproperty
a_mult_gate: assert property (p_mult_gate) else $error("multiplier gate");
property p_clear; o_clear_counters |-> !o_integrate_flag ##1 !o_clear_counters; endproperty
a_clear: assert property (p_clear) else $error("clear outside blanking");
property p_strobe; o_word_load_strobe |-> o_host_valid ##1 !o_word_load_strobe; endproperty
a_strobe: assert property (p_strobe) else $error("load strobe shape");
property p_first; o_clear_counters |-> ##2 o_word_load_strobe && o_host_word[15]; endproperty
a_first: assert property (p_first) else $error("first sign not one");
property p_flip; o_word_load_strobe && have |-> o_host_word[15] != last; endproperty
a_flip: assert property (p_flip) else $error("sign did not toggle");
property p_seq;
	o_sequence_state inside {8'h00, 8'h01, 8'h07, 8'h0F, 8'h1F, 8'h3F, 8'h7F,
		8'hFF, 8'hFE, 8'hF8, 8'hE0, 8'hC0, 8'h80};
endproperty
a_seq: assert property (p_seq) else $error("sequence state unlisted");
property p_seq_idx; o_seq_index == idx_exp; endproperty
a_seq_idx: assert property (p_seq_idx) else $error("sequence decode wrong");
property p_we; o_core_we |=> !o_core_we; endproperty
a_we: assert property (p_we) else $error("core write not a pulse");
property p_blank_min; $fell(o_integrate_flag) |=> !o_integrate_flag [*8]; endproperty
a_blank_min: assert property (p_blank_min) else $error("blanking too short");
endmodule // cca_core_chk
bind cca_core cca_core_chk cca_core_chk_i (.i_core_clk, .i_nrst, .o_card_chan,
	.o_core_we, .o_host_word, .o_host_valid, .o_word_load_strobe,
	.o_integrate_flag, .o_mult_clk_en, .o_clear_counters, .o_sequence_state,
	.o_seq_index);

/* File: cca_defs.vh */
// shared constants for the correlator core accumulate block
`ifndef CCA_DEFS_VH
`define CCA_DEFS_VH
`define CCA_CLK_NS        10
`define CCA_STEP_NS       750
`define CCA_PHASE_NS      250
`define CCA_ALIGN_NS      500
// cycle counts of the ns figures above at the 10ns clock
`define CCA_STEP_CYC      7'd75
`define CCA_PHASE_CYC     5'd25
`define CCA_ALIGN_CYC     6'd50
`define CCA_MS_TICKS      5'd20
`define CCA_CHANNELS      9'd416
`define CCA_LAST_WORD     9'd431
`define CCA_GROUP_LAST    3'd7
`define CCA_BIT_WEIGHT    3'd7
`define CCA_LO_BITS       15
`define CCA_HI_BITS       5
`define CCA_OFF_CTRL      4'h0
`define CCA_OFF_HALF      4'h4
`define CCA_OFF_STAT      4'h8
`define CCA_CTRL_RST      5'h10
`define CCA_HALF_RST      17'h0_1388
`define CCA_BLANK_MAX     4'hA
`define CCA_RESP_OK       2'b00
`define CCA_RESP_ERR      2'b10
`define CCA_ST_CAPT       2'd0
`define CCA_ST_RD         2'd1
`define CCA_ST_WR         2'd2
`define CCA_ST_HOLD       2'd3
`endif

/* File: cca_host_model.sv */
// host model: takes words, acks promptly or slowly, checks them
`timescale 1ns/1ps
module cca_host_model (
	input  wire        i_clk,
	input  wire        i_nrst,
	input  wire [15:0] i_word,
	input  wire        i_valid,
	input  wire        i_strobe,
	output reg         o_ack,
	output reg  [9:0]  o_bad,
	output reg  [3:0]  o_xfers
);
reg  [9:0]  cnt;
reg  [2:0]  wait_cnt;
reg         armed;
wire [8:0]  a = cnt[9:1];
wire [19:0] exp_w = {a, 2'b01, a};
wire        sign_bad = i_word[15] !== ~cnt[0];
wire        half_bad = cnt[0] ? i_word[4:0] !== exp_w[19:15]
	: i_word[14:0] !== exp_w[14:0];
always @(posedge i_clk)
begin
	o_ack <= 1'b0;
	if (!i_nrst)
	begin
		cnt <= 10'h000;
		o_bad <= 10'h000;
		o_xfers <= 4'h0;
		armed <= 1'b0;
		wait_cnt <= 3'h0;
	end
	else if (i_strobe)
	begin
		o_bad <= o_bad + {9'h000, sign_bad || half_bad};
		cnt <= (cnt == 10'h35F) ? 10'h000 : cnt + 10'h001;
		o_xfers <= o_xfers + {3'h0, cnt == 10'h35F};
		wait_cnt <= {cnt[2], 2'b00};
		armed <= 1'b1;
	end
	else if (armed && i_valid)
	begin
		o_ack <= wait_cnt == 3'h0;
		armed <= wait_cnt != 3'h0;
		wait_cnt <= wait_cnt - 3'h1;
	end
end
endmodule // cca_host_model
